// >>> i2cw_host_model.sv
/*
  host bus controller model: drives scl push-pull, sda as open drain.
  assumes the bench adds the sda pull-up and joins it with the device.
*/
`timescale 1ns/1ns
module i2cw_host_model (
  output logic scl,
  output logic sda_rel,
  input wire logic sda
);
  localparam int HALF = 160;
  initial begin
    scl = 1'b1;
    sda_rel = 1'b1;
  end
  // sda moves 40 ns into the low phase, clear of the synced scl fall
  task automatic bit_io(input logic b, output logic s);
    #40 sda_rel = b;
    #120 scl = 1'b1;
    #HALF s = sda;
    scl = 1'b0;
  endtask : bit_io
  task automatic send_start();
    #40 sda_rel = 1'b1;
    #120 scl = 1'b1;
    #HALF sda_rel = 1'b0;
    #HALF scl = 1'b0;
  endtask : send_start
  task automatic send_stop();
    #40 sda_rel = 1'b0;
    #120 scl = 1'b1;
    #HALF sda_rel = 1'b1;
    #HALF;
  endtask : send_stop
  task automatic write_byte(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) bit_io(b[i], s);
    bit_io(1'b1, s);
    ack = ~s;
  endtask : write_byte
  task automatic read_byte(input logic ack, output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, s);
      d[i] = s;
    end
    bit_io(~ack, s);
  endtask : read_byte
  // long low with scl left high; no clock at all
  task automatic wake_low(input int ns);
    sda_rel = 1'b0;
    #ns sda_rel = 1'b1;
  endtask : wake_low
endmodule : i2cw_host_model

// >>> i2cw_mem.sv
/*
  command input buffer: one write port, one registered read port.
  assumes writer and reader share clk; no reset of the contents.
*/
`timescale 1ns/1ns
module i2cw_mem #(
  parameter int W = 8,
  parameter int D = 128,
  parameter int AW = 7
) (
  input wire logic clk,
  input wire logic we,
  input wire logic [AW-1:0] wa,
  input wire logic [W-1:0] wd,
  input wire logic [AW-1:0] ra,
  output logic [W-1:0] rd
);
  logic [W-1:0] mem [D];
  logic [W-1:0] rd_reg;

  always_ff @(posedge clk) begin
    if (we) begin
      mem[wa] <= wd;
    end
    rd_reg <= mem[ra];
  end

  assign rd = rd_reg;
endmodule : i2cw_mem

// >>> i2cw_pkg.sv
/*
  constants, opcodes and state type shared by the i2c wake front end.
  assumes a single 25 MHz core clock for every module that imports it.
*/
package i2cw_pkg;
  localparam int CLK_MHZ = 25;
  // plain defaults for the three timing figures
  localparam int WAKE_LOW_TIME_NS = 60000;
  localparam int WAKE_TO_READY_DELAY_US = 2500;
  localparam int WDT_TIME_US = 1300000;
  // least times round up to whole cycles
  localparam int WAKE_LOW_CYC = (WAKE_LOW_TIME_NS * CLK_MHZ + 999) / 1000;
  localparam int WAKE_TO_READY_CYC = WAKE_TO_READY_DELAY_US * CLK_MHZ;
  localparam int WDT_CYC = WDT_TIME_US * CLK_MHZ;
  localparam int CNT_W = 26;
  localparam int BYTE_W = 8;
  localparam int PTR_W = 8;
  localparam int CMD_DEPTH = 128;
  localparam int CMD_AW = 7;
  localparam logic [3:0] BYTE_BITS = 4'h8;
  localparam int RW_BIT = 0;
  localparam int TTL_BIT = 3;
  localparam int ADDR_HI = 7;
  localparam int ADDR_LO = 1;
  localparam int MSB = 7;
  // word address functions
  localparam logic [7:0] WA_RESET = 8'h00;
  localparam logic [7:0] WA_SLEEP = 8'h01;
  localparam logic [7:0] WA_IDLE = 8'h02;
  localparam logic [7:0] WA_CMD = 8'h03;
  // byte position inside a packet
  localparam logic [1:0] IDX_ADDR = 2'h0;
  localparam logic [1:0] IDX_WORD = 2'h1;
  localparam logic [1:0] IDX_DATA = 2'h2;
  typedef enum logic [2:0] {
    S_SLEEP,
    S_WAKE,
    S_READY,
    S_RX,
    S_ACK,
    S_TX,
    S_RACK
  } i2cw_state_type;
endpackage : i2cw_pkg

// >>> i2cw_sync.sv
/*
  three flip-flop synchroniser for one pin, with level and edge pulses.
  assumes the pin is asynchronous to clk; edges come from stages two and three.
*/
`timescale 1ns/1ns
module i2cw_sync (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic pin,
  output logic lvl,
  output logic rise,
  output logic fall
);
  typedef struct packed {
    logic ff1;
    logic ff2;
    logic ff3;
    logic rise;
    logic fall;
  } i2cw_sync_type;
  i2cw_sync_type st_reg;
  i2cw_sync_type st_next;

  always_comb begin
    st_next = st_reg;
    st_next.ff1 = pin;
    st_next.ff2 = st_reg.ff1;
    st_next.ff3 = st_reg.ff2;
    st_next.rise = st_reg.ff2 & ~st_reg.ff3;
    st_next.fall = ~st_reg.ff2 & st_reg.ff3;
  end

  // idle bus is high, so reset to high avoids a false edge
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      st_reg <= '{ff1: 1'b1, ff2: 1'b1, ff3: 1'b1, rise: 1'b0, fall: 1'b0};
    end else begin
      st_reg <= st_next;
    end
  end

  assign lvl = st_reg.ff3;
  assign rise = st_reg.rise;
  assign fall = st_reg.fall;
endmodule : i2cw_sync

// >>> i2cw_top.sv
/*
  i2c target front end with sda long-low wake, byte receive/transmit,
  ack/nack, word address functions and command start.
  assumes scl and sda arrive asynchronously; addr_cfg, cmd_done and resp_data
  come from logic on clk; the pad turns sda_oe into an open-drain low.
*/
`timescale 1ns/1ns
module i2cw_top
  import i2cw_pkg::*;
#(
  parameter logic [CNT_W-1:0] WLO_CYC = CNT_W'(WAKE_LOW_CYC),
  parameter logic [CNT_W-1:0] WHI_CYC = CNT_W'(WAKE_TO_READY_CYC),
  parameter logic [CNT_W-1:0] WDT_LIM = CNT_W'(WDT_CYC)
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  input wire logic [BYTE_W-1:0] addr_cfg,
  output logic thr_ttl_sel,
  output logic awake,
  output logic busy,
  output logic cmd_go,
  input wire logic cmd_done,
  input wire logic [CMD_AW-1:0] cmd_rd_addr,
  output logic [BYTE_W-1:0] cmd_rd_data,
  output logic [PTR_W-1:0] resp_ptr,
  input wire logic [BYTE_W-1:0] resp_data
);
  typedef struct packed {
    i2cw_state_type state;
    logic [CNT_W-1:0] cnt;
    logic [CNT_W-1:0] wdt;
    logic [BYTE_W-1:0] shreg;
    logic [3:0] bit_cnt;
    logic [1:0] byte_idx;
    logic rw;
    logic acking;
    logic [BYTE_W-1:0] func;
    logic busy;
    logic cmd_go;
    logic [PTR_W-1:0] wr_ptr;
    logic [PTR_W-1:0] cmd_len;
    logic [PTR_W-1:0] resp_ptr;
    logic sda_oe;
    logic sda_o;
    logic awake;
    logic ttl_sel;
    logic cfg_taken;
    logic mem_we;
    logic [CMD_AW-1:0] mem_wa;
    logic [BYTE_W-1:0] mem_wd;
  } i2cw_top_type;

  i2cw_top_type st_reg;
  i2cw_top_type st_next;
  logic scl_s;
  logic scl_rise;
  logic scl_fall;
  logic sda_s;
  logic sda_rise;
  logic sda_fall;

  function automatic logic is_awake(input i2cw_state_type s);
    is_awake = (s != S_SLEEP) && (s != S_WAKE);
  endfunction : is_awake
  i2cw_sync u_scl_sync (
    .clk(clk),
    .rst_b(rst_b),
    .pin(scl_in),
    .lvl(scl_s),
    .rise(scl_rise),
    .fall(scl_fall)
  );
  i2cw_sync u_sda_sync (
    .clk(clk),
    .rst_b(rst_b),
    .pin(sda_in),
    .lvl(sda_s),
    .rise(sda_rise),
    .fall(sda_fall)
  );
  i2cw_mem #(
    .W(BYTE_W),
    .D(CMD_DEPTH),
    .AW(CMD_AW)
  ) u_cmd_mem (
    .clk(clk),
    .we(st_reg.mem_we),
    .wa(st_reg.mem_wa),
    .wd(st_reg.mem_wd),
    .ra(cmd_rd_addr),
    .rd(cmd_rd_data)
  );

  always_comb begin
    logic ack_now;
    logic [PTR_W-1:0] len_now;
    ack_now = 1'b0;
    len_now = st_reg.cmd_len;
    st_next = st_reg;
    st_next.cmd_go = 1'b0;
    st_next.mem_we = 1'b0;
    // threshold choice caught once after reset, then frozen
    if (!st_reg.cfg_taken) begin
      st_next.cfg_taken = 1'b1;
      st_next.ttl_sel = addr_cfg[TTL_BIT];
    end
    if (st_reg.busy && cmd_done) begin
      st_next.busy = 1'b0;
    end
    if (is_awake(st_reg.state)) begin
      st_next.wdt = st_reg.wdt + CNT_W'(1);
    end
    case (st_reg.state)
      // only sda low time is watched; scl is not looked at
      S_SLEEP: begin
        st_next.sda_oe = 1'b0;
        st_next.wdt = '0;
        if (sda_s) begin
          st_next.cnt = '0;
        end else if (st_reg.cnt >= WLO_CYC) begin
          st_next.state = S_WAKE;
          st_next.cnt = '0;
        end else begin
          st_next.cnt = st_reg.cnt + CNT_W'(1);
        end
      end
      S_WAKE: begin
        if (st_reg.cnt >= WHI_CYC - CNT_W'(1)) begin
          st_next.state = S_READY;
          st_next.awake = 1'b1;
          st_next.cnt = '0;
        end else begin
          st_next.cnt = st_reg.cnt + CNT_W'(1);
        end
      end
      S_READY: begin
        st_next.sda_oe = 1'b0;
      end
      S_RX: begin
        if (scl_rise) begin
          st_next.shreg = {st_reg.shreg[MSB-1:0], sda_s};
          st_next.bit_cnt = st_reg.bit_cnt + 4'h1;
        end else if (scl_fall && st_reg.bit_cnt == BYTE_BITS) begin
          st_next.bit_cnt = '0;
          st_next.state = S_ACK;
          if (st_reg.byte_idx == IDX_ADDR) begin
            st_next.rw = st_reg.shreg[RW_BIT];
            ack_now = (st_reg.shreg[ADDR_HI:ADDR_LO] == addr_cfg[ADDR_HI:ADDR_LO])
                      && !st_reg.busy;
            st_next.byte_idx = IDX_WORD;
          end else if (st_reg.byte_idx == IDX_WORD) begin
            ack_now = !st_reg.busy;
            st_next.func = st_reg.shreg;
            if (st_reg.shreg == WA_RESET && !st_reg.busy) begin
              st_next.wr_ptr = '0;
              st_next.resp_ptr = '0;
            end
            st_next.byte_idx = IDX_DATA;
          end else begin
            ack_now = !st_reg.busy;
            if (st_reg.func == WA_CMD && !st_reg.busy
                && st_reg.wr_ptr < PTR_W'(CMD_DEPTH)
                && (st_reg.wr_ptr == '0 || st_reg.wr_ptr < st_reg.cmd_len)) begin
              st_next.mem_we = 1'b1;
              st_next.mem_wa = st_reg.wr_ptr[CMD_AW-1:0];
              st_next.mem_wd = st_reg.shreg;
              if (st_reg.wr_ptr == '0) begin
                len_now = st_reg.shreg;
              end
              st_next.cmd_len = len_now;
              st_next.wr_ptr = st_reg.wr_ptr + PTR_W'(1);
              if (st_reg.wr_ptr + PTR_W'(1) == len_now) begin
                st_next.busy = 1'b1;
                st_next.cmd_go = 1'b1;
                st_next.wr_ptr = '0;
                st_next.cmd_len = '0;
              end
            end
          end
          st_next.acking = ack_now;
          st_next.sda_oe = ack_now;
        end
      end
      S_ACK: begin
        if (scl_fall) begin
          st_next.sda_oe = 1'b0;
          if (!st_reg.acking) begin
            st_next.state = S_READY;
          end else if (st_reg.rw) begin
            st_next.state = S_TX;
            st_next.sda_oe = ~resp_data[MSB];
            st_next.shreg = {resp_data[MSB-1:0], 1'b0};
            st_next.bit_cnt = 4'h1;
          end else begin
            st_next.state = S_RX;
          end
        end
      end
      S_TX: begin
        if (scl_fall) begin
          if (st_reg.bit_cnt == BYTE_BITS) begin
            st_next.sda_oe = 1'b0;
            st_next.state = S_RACK;
            st_next.resp_ptr = st_reg.resp_ptr + PTR_W'(1);
          end else begin
            st_next.sda_oe = ~st_reg.shreg[MSB];
            st_next.shreg = {st_reg.shreg[MSB-1:0], 1'b0};
            st_next.bit_cnt = st_reg.bit_cnt + 4'h1;
          end
        end
      end
      S_RACK: begin
        if (scl_rise) begin
          st_next.acking = !sda_s;
        end else if (scl_fall) begin
          if (st_reg.acking) begin
            st_next.state = S_TX;
            st_next.sda_oe = ~resp_data[MSB];
            st_next.shreg = {resp_data[MSB-1:0], 1'b0};
            st_next.bit_cnt = 4'h1;
          end else begin
            st_next.state = S_READY;
          end
        end
      end
      default: begin
        st_next.state = S_SLEEP;
      end
    endcase
    // a wake pattern while awake is just traffic; sda moving as scl rises is data
    if (is_awake(st_reg.state) && scl_s && !scl_rise) begin
      if (sda_fall) begin
        st_next.state = S_RX;
        st_next.bit_cnt = '0;
        st_next.byte_idx = IDX_ADDR;
        st_next.func = WA_CMD;
        st_next.sda_oe = 1'b0;
      end else if (sda_rise) begin
        st_next.state = S_READY;
        st_next.sda_oe = 1'b0;
        if (st_reg.func == WA_SLEEP || st_reg.func == WA_IDLE) begin
          st_next.state = S_SLEEP;
          st_next.awake = 1'b0;
          st_next.wr_ptr = '0;
          st_next.cmd_len = '0;
          st_next.resp_ptr = '0;
        end else if (!st_reg.busy && st_reg.cmd_len != '0
                     && st_reg.wr_ptr >= st_reg.cmd_len) begin
          st_next.busy = 1'b1;
          st_next.cmd_go = 1'b1;
          st_next.wr_ptr = '0;
          st_next.cmd_len = '0;
        end
        st_next.func = WA_CMD;
      end
    end
    // watchdog expiry WDT_LIM awake cycles after wake, traffic or not, clears state, busy and the command pointers; the command buffer contents are kept
    if (is_awake(st_reg.state) && st_reg.wdt >= WDT_LIM) begin
      st_next.state = S_SLEEP;
      st_next.awake = 1'b0;
      st_next.sda_oe = 1'b0;
      st_next.busy = 1'b0;
      st_next.cmd_go = 1'b0;
      st_next.cnt = '0;
      st_next.wdt = '0;
      st_next.wr_ptr = '0;
      st_next.cmd_len = '0;
      st_next.resp_ptr = '0;
      st_next.func = WA_CMD;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      st_reg <= '0;
      st_reg.state <= S_SLEEP;
      st_reg.func <= WA_CMD;
    end else begin
      st_reg <= st_next;
    end
  end

  assign sda_out = st_reg.sda_o;
  assign sda_oe = st_reg.sda_oe;
  assign thr_ttl_sel = st_reg.ttl_sel;
  assign awake = st_reg.awake;
  assign busy = st_reg.busy;
  assign cmd_go = st_reg.cmd_go;
  assign resp_ptr = st_reg.resp_ptr;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  property p_sleep_quiet;
    (st_reg.state == S_SLEEP) |-> !sda_oe && !awake;
  endproperty
  a_sleep_quiet: assert property (p_sleep_quiet) else $error("drive while asleep");
  property p_wake_low;
    (st_reg.state == S_SLEEP && st_reg.cnt == WLO_CYC && !sda_s) |=> st_reg.state == S_WAKE;
  endproperty
  a_wake_low: assert property (p_wake_low) else $error("long low did not wake");
  property p_wake_blind;
    (st_reg.state == S_WAKE && st_reg.cnt < WHI_CYC - CNT_W'(1))
      |=> st_reg.state inside {S_WAKE, S_SLEEP} && !sda_oe;
  endproperty
  a_wake_blind: assert property (p_wake_blind) else $error("bus seen while waking");
  property p_nomatch_quiet;
    (st_reg.state == S_ACK && !st_reg.acking) |-> !sda_oe;
  endproperty
  a_nomatch_quiet: assert property (p_nomatch_quiet) else $error("nack state drives");
  property p_start;
    (is_awake(st_reg.state) && scl_s && !scl_rise && sda_fall && st_reg.wdt < WDT_LIM)
      |=> st_reg.state == S_RX && st_reg.bit_cnt == 4'h0 && st_reg.byte_idx == IDX_ADDR;
  endproperty
  a_start: assert property (p_start) else $error("start not taken");
  property p_stop;
    (is_awake(st_reg.state) && scl_s && !scl_rise && sda_rise && !sda_fall)
      |=> st_reg.state inside {S_READY, S_SLEEP} && !sda_oe;
  endproperty
  a_stop: assert property (p_stop) else $error("stop did not end transfer");
  property p_busy_nack;
    (st_reg.state == S_RX && st_reg.busy && !cmd_done && scl_fall
     && st_reg.bit_cnt == BYTE_BITS && !(scl_s && (sda_fall || sda_rise))
     && st_reg.wdt < WDT_LIM) |=> st_reg.state == S_ACK ##1 !sda_oe;
  endproperty
  a_busy_nack: assert property (p_busy_nack) else $error("acked while busy");
  property p_count_go;
    $rose(cmd_go) |-> busy && st_reg.wr_ptr == '0 && $past(st_reg.state) inside {S_RX, S_READY,
      S_ACK, S_TX, S_RACK};
  endproperty
  a_count_go: assert property (p_count_go) else $error("start without command");
  property p_wdt;
    (is_awake(st_reg.state) && st_reg.wdt >= WDT_LIM) |=> st_reg.state == S_SLEEP ##1 !busy;
  endproperty
  a_wdt: assert property (p_wdt) else $error("watchdog did not sleep");
  property p_open_drain;
    sda_oe |-> !sda_out;
  endproperty
  a_open_drain: assert property (p_open_drain) else $error("sda driven high");
  c_wake: cover property (st_reg.state == S_WAKE ##1 st_reg.state == S_READY);
  c_ack: cover property (st_reg.state == S_ACK && sda_oe);
  c_go: cover property (cmd_go);
  c_tx: cover property (st_reg.state == S_RACK ##1 st_reg.state == S_TX);
endmodule : i2cw_top

// >>> i2cw_top_tb.sv
/*
  self-checking bench for the i2c wake front end.
  assumes the host model above and shortened wake and watchdog counts.
*/
`timescale 1ns/1ns
module i2cw_top_tb;
  import i2cw_pkg::*;
  localparam logic [7:0] CFG = 8'hc8;
  logic clk, rst_b, scl, sda_rel, sda_out, sda_oe, thr_ttl_sel, awake, busy;
  logic cmd_go, cmd_done, a;
  logic [7:0] addr_cfg, cmd_rd_data, resp_ptr, resp_data, d;
  logic [CMD_AW-1:0] cmd_rd_addr;
  wire sda;
  int mismatches, samples_checked, cycles, go_count;
  assign sda = sda_rel & (sda_oe ? sda_out : 1'b1);
  assign resp_data = 8'h30 + resp_ptr;
  i2cw_top #(.WLO_CYC(26'd20), .WHI_CYC(26'd30), .WDT_LIM(26'd20000)) i2cw_top_inst (
    .clk(clk), .rst_b(rst_b), .scl_in(scl), .sda_in(sda), .sda_out(sda_out),
    .sda_oe(sda_oe), .addr_cfg(addr_cfg), .thr_ttl_sel(thr_ttl_sel), .awake(awake),
    .busy(busy), .cmd_go(cmd_go), .cmd_done(cmd_done), .cmd_rd_addr(cmd_rd_addr),
    .cmd_rd_data(cmd_rd_data), .resp_ptr(resp_ptr), .resp_data(resp_data)
  );
  i2cw_host_model i2cw_host_model_inst (.scl(scl), .sda_rel(sda_rel), .sda(sda));
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles++;
    if (cmd_go === 1'b1) go_count++;
    if (cycles == 60000) begin
      mismatches++;
      end_of_test();
    end
  end
  task automatic check(input logic ok, input string msg);
    samples_checked++;
    if (ok !== 1'b1) begin
      mismatches++;
      $display("mismatch at %0t: %s", $time, msg);
    end
  endtask : check
  task automatic end_of_test();
    $display("mismatches %0d, samples_checked %0d", mismatches, samples_checked);
    if (mismatches == 0 && samples_checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : end_of_test
  task automatic wait_awake(input logic v, input int n);
    for (int i = 0; i < n && awake !== v; i++) begin
      @(posedge clk);
      #1;
    end
  endtask : wait_awake
  task automatic wr(input logic [7:0] b, input logic exp, input string msg);
    i2cw_host_model_inst.write_byte(b, a);
    check(a === exp, msg);
  endtask : wr
  task automatic t_reset();
    check(awake === 1'b0 && busy === 1'b0 && sda_oe === 1'b0, "reset outputs");
    check(sda_out === 1'b0 && cmd_go === 1'b0, "open drain output high");
    check(thr_ttl_sel === CFG[TTL_BIT], "threshold select");
    addr_cfg[TTL_BIT] = ~CFG[TTL_BIT];
    repeat (4) @(posedge clk);
    check(thr_ttl_sel === CFG[TTL_BIT], "threshold not frozen");
    #1 addr_cfg = CFG;
  endtask : t_reset
  // all-high byte keeps every low short of the wake time
  task automatic t_asleep();
    i2cw_host_model_inst.send_start();
    wr(8'hff, 1'b0, "ack while asleep");
    i2cw_host_model_inst.send_stop();
    check(awake === 1'b0, "woke on traffic");
  endtask : t_asleep
  task automatic t_wake();
    i2cw_host_model_inst.wake_low(1200);
    check(awake === 1'b0, "ready before delay");
    wait_awake(1'b1, 100);
    check(awake === 1'b1, "no wake");
  endtask : t_wake
  task automatic t_miss();
    i2cw_host_model_inst.send_start();
    wr(8'h50, 1'b0, "ack to other address");
    i2cw_host_model_inst.send_stop();
  endtask : t_miss
  task automatic t_cmd();
    logic [7:0] exp [3];
    int g;
    exp = '{8'h03, 8'ha5, 8'h5a};
    g = go_count;
    i2cw_host_model_inst.send_start();
    wr(CFG, 1'b1, "address nack");
    wr(WA_CMD, 1'b1, "word nack");
    for (int i = 0; i < 3; i++) wr(exp[i], 1'b1, "data nack");
    check(go_count == g + 1 && busy === 1'b1, "no start on count");
    i2cw_host_model_inst.send_stop();
    check(go_count == g + 1 && busy === 1'b1, "stop after command");
    for (int i = 0; i < 3; i++) begin
      @(posedge clk);
      #1 cmd_rd_addr = CMD_AW'(i);
      @(posedge clk);
      #1 check(cmd_rd_data === exp[i], "buffer content");
    end
    i2cw_host_model_inst.send_start();
    wr(CFG | 8'h01, 1'b0, "ack while busy");
    i2cw_host_model_inst.send_stop();
    @(posedge clk);
    #1 cmd_done = 1'b1;
    @(posedge clk);
    #1 cmd_done = 1'b0;
    repeat (3) @(posedge clk);
    #1 check(busy === 1'b0, "busy stuck");
  endtask : t_cmd
  task automatic t_read();
    i2cw_host_model_inst.send_start();
    wr(CFG, 1'b1, "address nack");
    wr(WA_RESET, 1'b1, "reset word nack");
    i2cw_host_model_inst.send_stop();
    i2cw_host_model_inst.send_start();
    wr(CFG | 8'h01, 1'b1, "read address nack");
    i2cw_host_model_inst.read_byte(1'b1, d);
    check(d === 8'h30, "first read byte");
    i2cw_host_model_inst.read_byte(1'b0, d);
    check(d === 8'h31, "second read byte");
    check(resp_ptr === 8'h02, "response pointer");
    i2cw_host_model_inst.send_stop();
  endtask : t_read
  task automatic t_rewake();
    i2cw_host_model_inst.wake_low(1200);
    repeat (100) @(posedge clk);
    #1 check(awake === 1'b1, "rewake changed state");
  endtask : t_rewake
  task automatic t_sleep(input logic [7:0] f);
    i2cw_host_model_inst.send_start();
    wr(CFG, 1'b1, "address nack");
    wr(f, 1'b1, "word nack");
    i2cw_host_model_inst.send_stop();
    repeat (8) @(posedge clk);
    #1 check(awake === 1'b0, "still awake");
    t_wake();
  endtask : t_sleep
  task automatic t_wdt();
    wait_awake(1'b0, 21000);
    check(awake === 1'b0, "watchdog silent");
  endtask : t_wdt
  initial begin
    rst_b = 1'b0;
    addr_cfg = CFG;
    cmd_done = 1'b0;
    cmd_rd_addr = '0;
    repeat (10) @(posedge clk);
    #1 rst_b = 1'b1;
    @(posedge clk);
    #1;
    t_reset();
    t_asleep();
    t_wake();
    t_miss();
    t_cmd();
    t_read();
    t_rewake();
    t_sleep(WA_SLEEP);
    t_sleep(WA_IDLE);
    t_wdt();
    end_of_test();
  end
endmodule : i2cw_top_tb
